// [tcr_bus_model.sv]
// Far side of the data line: pulled-up open-drain wire, strong pullup and sensor front end
`timescale 1ns/1ps
module tcr_bus_model (
   input  wire logic        dq_out,       // Device data line value
   input  wire logic        dq_oe_b,      // Device data line enable, active low
   input  wire logic        strong_pu,    // Master strong pullup enable
   input  wire logic [11:0] dac_code,     // Trial code from the device
   input  wire logic [11:0] sens_target,  // Sensed temperature, offset-binary
   output logic             dq_line,      // Resolved data line level
   output logic             sens_cmp      // Temperature at or above trial
);
   // The weak pullup wins whenever nobody pulls low; the strong pullup forces high
   always_comb
   begin
      if (strong_pu)
         dq_line = 1'b1;
      else if (!dq_oe_b)
         dq_line = dq_out;
      else
         dq_line = 1'b1;
   end

   assign sens_cmp = (sens_target >= dac_code);
endmodule : tcr_bus_model

// [tcr_pkg.sv]
// Shared constants and types for the temperature conversion readout core
package tcr_pkg;

   // Command code that starts a temperature conversion
   localparam logic [7:0]  CMD_CONVERT    = 8'h44;

   // Result register values, 16-bit sign-extended two's complement, LSB = 1/16 C
   localparam logic [15:0] TEMP_RESET     = 16'h0550;
   localparam logic [15:0] TEMP_MIN       = 16'hfc90;
   localparam logic [15:0] TEMP_MAX       = 16'h07d0;
   localparam int unsigned TEMP_SIGN_LSB  = 11;

   // Resolution field and encodings
   localparam int unsigned CFG_RES_LSB    = 5;
   localparam logic [1:0]  RES_9          = 2'h0;
   localparam logic [1:0]  RES_10         = 2'h1;
   localparam logic [1:0]  RES_11         = 2'h2;
   localparam logic [1:0]  RES_12         = 2'h3;
   localparam int unsigned RES_MIN_BITS   = 9;

   // Retained byte store layout
   localparam logic [2:0]  NV_ALARM_HI    = 3'h0;
   localparam logic [2:0]  NV_ALARM_LO    = 3'h1;
   localparam logic [2:0]  NV_CONFIG      = 3'h2;
   localparam logic [2:0]  NV_USER0       = 3'h3;
   localparam logic [2:0]  NV_USER1       = 3'h4;
   localparam int unsigned NV_DEPTH       = 5;

   // Successive approximation converter
   localparam int unsigned SAR_BITS       = 12;
   localparam logic [11:0] SAR_MID        = 12'h800;
   localparam int unsigned STEP_W         = 23;

   // Timing: longest 12-bit conversion, clock rate and fixed cycle overhead
   localparam int unsigned CONV_MS_12     = 400;
   localparam int unsigned MCLK_KHZ       = 125000;
   localparam int unsigned CONV_CYCLES_12 = CONV_MS_12 * MCLK_KHZ;
   localparam int unsigned CONV_OVERHEAD  = 4;

   // Device serial code; value is arbitrary
   localparam logic [63:0] SERIAL_DEFAULT = 64'h5a00_0000_0000_0001;

   typedef enum logic {TCR_IDLE, TCR_CONV} tcr_state_t;
   typedef enum logic {TCR_SAR_IDLE, TCR_SAR_RUN} tcr_sar_state_t;

endpackage : tcr_pkg

// [tcr_sar.sv]
// Successive approximation engine with per-bit settling timer
`timescale 1ns/1ps
module tcr_sar #(
   parameter int unsigned STEP_CYCLES = 16
) (
   input wire logic mclk,      // System clock
   input wire logic rst_b,     // Asynchronous reset, active low
   input wire logic clk_en,    // Freezes all state while low
   tcr_sar_if.sar   sar_port   // Control side
);

   typedef struct packed {
      tcr_pkg::tcr_sar_state_t       st;
      logic [3:0]                    bit_idx;
      logic [3:0]                    left;
      logic [tcr_pkg::STEP_W-1:0]    cnt;
      logic [11:0]                   code;
      logic [11:0]                   trial;
      logic                          done;
   } tcr_sar_reg_t;

   localparam tcr_sar_reg_t SAR_RST = '{tcr_pkg::TCR_SAR_IDLE, 4'h0, 4'h0, '0, 12'h000, 12'h000, 1'b0};
   localparam logic [tcr_pkg::STEP_W-1:0] STEP_LAST = tcr_pkg::STEP_W'(STEP_CYCLES - 1);

   tcr_sar_reg_t state;
   tcr_sar_reg_t next_state;
   logic [11:0]  kept;

   always_comb
   begin
      next_state = state;
      next_state.done = 1'b0;
      // Drop the trial bit when the sensed temperature lies below the trial level
      kept = sar_port.cmp ? state.trial : (state.trial & ~(12'h001 << state.bit_idx));
      case (state.st)
         tcr_pkg::TCR_SAR_IDLE:
         begin
            if (sar_port.start)
            begin
               next_state.st      = tcr_pkg::TCR_SAR_RUN;
               next_state.bit_idx = 4'(tcr_pkg::SAR_BITS - 1);
               next_state.left    = sar_port.nbits;
               next_state.cnt     = '0;
               next_state.code    = 12'h000;
               next_state.trial   = tcr_pkg::SAR_MID;
            end
         end
         tcr_pkg::TCR_SAR_RUN:
         begin
            if (state.cnt == STEP_LAST)
            begin
               next_state.cnt  = '0;
               next_state.code = kept;
               if (state.left == 4'h1)
               begin
                  // Unresolved low bits stay zero at reduced resolution
                  next_state.st    = tcr_pkg::TCR_SAR_IDLE;
                  next_state.done  = 1'b1;
                  next_state.trial = kept;
               end
               else
               begin
                  next_state.left    = state.left - 4'h1;
                  next_state.bit_idx = state.bit_idx - 4'h1;
                  next_state.trial   = kept | (12'h001 << (state.bit_idx - 4'h1));
               end
            end
            else
            begin
               next_state.cnt = state.cnt + tcr_pkg::STEP_W'(1);
            end
         end
         default:
         begin
            next_state = SAR_RST;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state <= SAR_RST;
      else if (clk_en)
         state <= next_state;
   end

   assign sar_port.busy  = (state.st == tcr_pkg::TCR_SAR_RUN);
   assign sar_port.done  = state.done;
   assign sar_port.code  = state.code;
   assign sar_port.trial = state.trial;

endmodule : tcr_sar

// [tcr_sar_if.sv]
// Handshake between conversion control and the approximation engine
`timescale 1ns/1ps
interface tcr_sar_if;
   logic        start;   // One-cycle start pulse
   logic [3:0]  nbits;   // Bits to resolve, 9 to 12
   logic        cmp;     // Synchronised comparator: temperature >= trial
   logic        busy;    // Engine running
   logic        done;    // One-cycle pulse, code valid
   logic [11:0] code;    // Offset-binary result
   logic [11:0] trial;   // Current trial code to the front end

   modport ctl (output start, nbits, cmp, input busy, done, code, trial);
   modport sar (input start, nbits, cmp, output busy, done, code, trial);
endinterface : tcr_sar_if

// [tcr_temp_readout.sv]
// Temperature conversion readout core: command, conversion control, result and retained bytes
`timescale 1ns/1ps

module tcr_temp_readout #(
   parameter int unsigned CONV_CYCLES = tcr_pkg::CONV_CYCLES_12,   // Longest conversion in clock cycles
   parameter logic [63:0] SERIAL_CODE = tcr_pkg::SERIAL_DEFAULT    // Unique device code; value is arbitrary
) (
   input  wire logic        mclk,          // 125 MHz system clock
   input  wire logic        rst_b,         // Asynchronous reset, active low
   input  wire logic        clk_en,        // Freezes all state while low
   input  wire logic        cmd_valid,     // Function command byte received, one-cycle pulse
   input  wire logic [7:0]  cmd_code,      // Function command byte
   input  wire logic        rd_slot,       // Read slot sampling window, level
   input  wire logic        vdd_pin,       // External supply present (pin)
   input  wire logic        sens_cmp,      // Sensor comparator: temperature >= trial (pin)
   input  wire logic        nv_wr,         // Retained byte write strobe
   input  wire logic        nv_rd,         // Retained byte read strobe
   input  wire logic [2:0]  nv_addr,       // Retained byte index
   input  wire logic [7:0]  nv_wdata,      // Retained byte write data
   output logic      [7:0]  nv_rdata,      // Retained byte read data
   output logic      [15:0] temp_result,   // Temperature result register
   output logic             rd_bit,        // Completion bit for read slots: 0 busy, 1 done
   output logic             dq_out,        // Data line output value, always low
   output logic             dq_oe_b,       // Data line output enable, active low
   output logic      [11:0] dac_code,      // Trial code to the sensing front end
   output logic             conv_busy,     // Conversion in progress
   output logic      [63:0] serial_code    // Device serial code
);

   typedef struct packed {
      tcr_pkg::tcr_state_t st;
      logic                start;
      logic                vdd_s1;
      logic                vdd_s2;
      logic                cmp_s1;
      logic                cmp_s2;
      logic [1:0]          res;
      logic [15:0]         temp;
      logic                rd_bit;
      logic                dq_oe_b;
      logic                dq_out;
      logic [7:0]          nv_rdata;
      logic [63:0]         serial;
   } tcr_reg_t;

   localparam tcr_reg_t TOP_RST = '{tcr_pkg::TCR_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, tcr_pkg::RES_12,
                                    tcr_pkg::TEMP_RESET, 1'b1, 1'b1, 1'b0, 8'h00, SERIAL_CODE};
   // Leave room for the start and finish cycles around the timed steps
   localparam int unsigned STEP_CYCLES = (CONV_CYCLES - tcr_pkg::CONV_OVERHEAD) / tcr_pkg::SAR_BITS;

   tcr_reg_t    state;
   tcr_reg_t    next_state;
   logic [7:0]  nv_mem [tcr_pkg::NV_DEPTH];
   tcr_sar_if   sar_bus ();

   // Number of bits resolved for a resolution setting
   function automatic logic [3:0] res_bits(input logic [1:0] res);
      res_bits = 4'(tcr_pkg::RES_MIN_BITS) + {2'b00, res};
   endfunction : res_bits

   // Offset-binary code to sign-extended, range-limited result
   function automatic logic [15:0] to_result(input logic [11:0] code);
      logic [11:0] v;
      logic [15:0] t;
      v = code ^ tcr_pkg::SAR_MID;
      t = {{4{v[11]}}, v};
      if ($signed(t) < $signed(tcr_pkg::TEMP_MIN))
         to_result = tcr_pkg::TEMP_MIN;
      else if ($signed(t) > $signed(tcr_pkg::TEMP_MAX))
         to_result = tcr_pkg::TEMP_MAX;
      else
         to_result = t;
   endfunction : to_result

   always_comb
   begin
      next_state = state;
      next_state.start  = 1'b0;
      next_state.vdd_s1 = vdd_pin;
      next_state.vdd_s2 = state.vdd_s1;
      next_state.cmp_s1 = sens_cmp;
      next_state.cmp_s2 = state.cmp_s1;
      next_state.dq_out = 1'b0;
      case (state.st)
         tcr_pkg::TCR_IDLE:
         begin
            // Only the convert command leaves idle; other commands belong to other logic
            if (cmd_valid && cmd_code == tcr_pkg::CMD_CONVERT)
            begin
               next_state.st    = tcr_pkg::TCR_CONV;
               next_state.start = 1'b1;
            end
         end
         tcr_pkg::TCR_CONV:
         begin
            // A repeated convert command during a conversion is ignored
            if (sar_bus.done)
            begin
               next_state.temp = to_result(sar_bus.code);
               next_state.st   = tcr_pkg::TCR_IDLE;
            end
         end
         default:
         begin
            next_state.st = tcr_pkg::TCR_IDLE;
         end
      endcase
      next_state.rd_bit = (state.st != tcr_pkg::TCR_CONV);
      // Only an externally supplied device may pull the line for a busy answer;
      // on parasite power the master holds a strong pullup and does not poll
      next_state.dq_oe_b = !(rd_slot && state.vdd_s2 && state.st == tcr_pkg::TCR_CONV);
      // A new resolution takes effect at the next conversion start
      if (nv_wr && nv_addr == tcr_pkg::NV_CONFIG)
         next_state.res = nv_wdata[tcr_pkg::CFG_RES_LSB +: 2];
      if (nv_rd)
      begin
         if (32'(nv_addr) < tcr_pkg::NV_DEPTH)
            next_state.nv_rdata = nv_mem[nv_addr];
         else
            next_state.nv_rdata = 8'h00;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         state <= TOP_RST;
      else if (clk_en)
         state <= next_state;
   end

   // Retained bytes carry no reset so they survive a logic reset
   always_ff @(posedge mclk)
   begin
      if (clk_en && nv_wr && 32'(nv_addr) < tcr_pkg::NV_DEPTH)
         nv_mem[nv_addr] <= nv_wdata;
   end

   assign sar_bus.start = state.start;
   assign sar_bus.nbits = res_bits(state.res);
   assign sar_bus.cmp   = state.cmp_s2;

   tcr_sar #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_sar (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .sar_port (sar_bus.sar)
   );

   assign nv_rdata    = state.nv_rdata;
   assign temp_result = state.temp;
   assign rd_bit      = state.rd_bit;
   assign dq_out      = state.dq_out;
   assign dq_oe_b     = state.dq_oe_b;
   assign dac_code    = sar_bus.trial;
   assign conv_busy   = (state.st == tcr_pkg::TCR_CONV);
   assign serial_code = state.serial;

   // Helper state observed only by the checks below
   logic        ever_done;
   logic        cfg_written;
   logic [31:0] conv_cnt;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ever_done   <= 1'b0;
         cfg_written <= 1'b0;
         conv_cnt    <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (state.st == tcr_pkg::TCR_CONV && sar_bus.done)
            ever_done <= 1'b1;
         if (nv_wr && nv_addr == tcr_pkg::NV_CONFIG)
            cfg_written <= 1'b1;
         if (state.st == tcr_pkg::TCR_CONV)
            conv_cnt <= conv_cnt + 32'h0000_0001;
         else
            conv_cnt <= 32'h0000_0000;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_cmd_taken;
      clk_en && state.st == tcr_pkg::TCR_IDLE && cmd_valid && cmd_code == tcr_pkg::CMD_CONVERT;
   endsequence

   sequence s_conv_end;
      clk_en && state.st == tcr_pkg::TCR_CONV && sar_bus.done;
   endsequence

   a_cmd_starts_conv: assert property (s_cmd_taken |=> conv_busy && state.start)
      else $error("convert command did not start a conversion");

   a_idle_stays_idle: assert property (clk_en && !conv_busy && !(cmd_valid && cmd_code == tcr_pkg::CMD_CONVERT)
                                       |=> !conv_busy)
      else $error("conversion began without a command");

   a_end_loads_result: assert property (s_conv_end |=> !conv_busy
                                        && temp_result == to_result($past(sar_bus.code)))
      else $error("finished conversion did not load the result");

   a_busy_answers_zero: assert property (clk_en && conv_busy |=> !rd_bit)
      else $error("read slot answer not 0 during conversion");

   a_idle_answers_one: assert property (clk_en && !conv_busy |=> rd_bit)
      else $error("read slot answer not 1 when idle");

   a_parasite_no_pull: assert property (clk_en && !state.vdd_s2 |=> dq_oe_b && !dq_out)
      else $error("data line pulled while on parasite power");

   a_power_on_value: assert property (!ever_done |-> temp_result == tcr_pkg::TEMP_RESET)
      else $error("result changed without a conversion");

   a_res_default: assert property (!cfg_written |-> sar_bus.nbits == 4'(tcr_pkg::SAR_BITS))
      else $error("resolution not twelve bits after reset");

   a_sign_extended: assert property (temp_result[15:tcr_pkg::TEMP_SIGN_LSB] == 5'h00
                                     || temp_result[15:tcr_pkg::TEMP_SIGN_LSB] == 5'h1f)
      else $error("result not sign extended");

   a_result_span: assert property ($signed(temp_result) >= $signed(tcr_pkg::TEMP_MIN)
                                   && $signed(temp_result) <= $signed(tcr_pkg::TEMP_MAX))
      else $error("result outside measurable span");

   a_conv_time_max: assert property (conv_cnt <= CONV_CYCLES)
      else $error("conversion exceeded its longest time");

   a_engine_in_conv: assert property (sar_bus.busy |-> conv_busy)
      else $error("approximation engine running outside a conversion");

endmodule : tcr_temp_readout

// [testbench.sv]
// Self-checking testbench for the temperature conversion readout core
`timescale 1ns/1ps
module testbench;
   localparam int unsigned CONV_CYC = 40;
   logic mclk, rst_b, clk_en, cmd_valid, rd_slot, vdd_pin, sens_cmp, nv_wr, nv_rd, strong_pu;
   logic [7:0] cmd_code, nv_wdata, nv_rdata;
   logic [2:0] nv_addr;
   logic [15:0] temp_result;
   logic rd_bit, dq_out, dq_oe_b, conv_busy, dq_line;
   logic [11:0] dac_code, target;
   logic [63:0] serial_code;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc_cnt = 0;

   tcr_temp_readout #(.CONV_CYCLES(CONV_CYC), .SERIAL_CODE(64'h0123_4567_89ab_cdef)) dut_u (
      .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .rd_slot(rd_slot), .vdd_pin(vdd_pin), .sens_cmp(sens_cmp), .nv_wr(nv_wr), .nv_rd(nv_rd),
      .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .temp_result(temp_result),
      .rd_bit(rd_bit), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .dac_code(dac_code),
      .conv_busy(conv_busy), .serial_code(serial_code));

   tcr_bus_model model_u (.dq_out(dq_out), .dq_oe_b(dq_oe_b), .strong_pu(strong_pu),
      .dac_code(dac_code), .sens_target(target), .dq_line(dq_line), .sens_cmp(sens_cmp));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic finish_test;
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   // Hang guard, far above the few hundred cycles the scenarios need
   always @(posedge mclk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000)
      begin
         error_cnt++;
         $display("[ERR] %0t timeout", $time);
         finish_test();
      end
   end

   task automatic chk_word(input logic [63:0] got, input logic [63:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({63'h0, got}, {63'h0, exp}, what);
   endtask : chk_bit

   task automatic send_cmd(input logic [7:0] code);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_code  <= code;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      #1;
   endtask : send_cmd

   // Holds a read slot for three edges and checks the line answer after the second
   task automatic read_slot(input logic exp_bit);
      @(posedge mclk);
      rd_slot <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk_bit(rd_bit, exp_bit, "read slot bit");
      chk_bit(dq_line, exp_bit | ~vdd_pin, "line level");
      @(posedge mclk);
      rd_slot <= 1'b0;
   endtask : read_slot

   task automatic nv_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      nv_wr    <= 1'b1;
      nv_addr  <= a;
      nv_wdata <= d;
      @(posedge mclk);
      nv_wr <= 1'b0;
   endtask : nv_write

   task automatic nv_read(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk);
      nv_rd   <= 1'b1;
      nv_addr <= a;
      @(posedge mclk);
      nv_rd <= 1'b0;
      #1;
      chk_word({56'h0, nv_rdata}, {56'h0, exp}, "retained byte");
   endtask : nv_read

   function automatic logic [15:0] exp_temp(input logic [11:0] ob, input logic [1:0] res);
      logic [11:0] t;
      logic signed [15:0] v;
      t = (ob ^ 12'h0800) & (12'hfff << (2'd3 - res));
      v = {{4{t[11]}}, t};
      if (v > $signed(tcr_pkg::TEMP_MAX))
         v = tcr_pkg::TEMP_MAX;
      if (v < $signed(tcr_pkg::TEMP_MIN))
         v = tcr_pkg::TEMP_MIN;
      return v;
   endfunction : exp_temp

   // One conversion: busy answer right after the command on external supply only, bounded completion, result, then done answer
   task automatic conv_run(input logic [11:0] ob, input logic [1:0] res);
      int n;
      int t0;
      target <= ob;
      send_cmd(tcr_pkg::CMD_CONVERT);
      t0 = cyc_cnt;
      chk_bit(conv_busy, 1'b1, "busy after command");
      strong_pu <= ~vdd_pin;
      if (vdd_pin)
         read_slot(1'b0);
      send_cmd(tcr_pkg::CMD_CONVERT);
      // Cycles counted from the edge that took the command
      n = cyc_cnt - t0;
      while (conv_busy === 1'b1 && n < CONV_CYC + 8)
      begin
         @(posedge mclk);
         #1;
         n = cyc_cnt - t0;
      end
      strong_pu <= 1'b0;
      chk_bit(conv_busy, 1'b0, "conversion ended");
      chk_bit(n <= CONV_CYC, 1'b1, "conversion time");
      chk_word({48'h0, temp_result}, {48'h0, exp_temp(ob, res)}, "result");
      repeat (2) @(posedge mclk);
      #1;
      chk_bit(conv_busy, 1'b0, "stays idle");
      read_slot(1'b1);
   endtask : conv_run

   task automatic t_reset;
      #1;
      chk_word({48'h0, temp_result}, {48'h0, tcr_pkg::TEMP_RESET}, "reset result");
      chk_word(serial_code, 64'h0123_4567_89ab_cdef, "serial code");
      repeat (30) @(posedge mclk);
      #1;
      chk_bit(conv_busy, 1'b0, "idle without command");
      chk_bit(dq_oe_b, 1'b1, "line released");
      read_slot(1'b1);
      send_cmd(8'h45);
      chk_bit(conv_busy, 1'b0, "other code ignored");
   endtask : t_reset

   // Command offered while the clock enable is low must be lost
   task automatic t_freeze;
      @(posedge mclk);
      clk_en <= 1'b0;
      send_cmd(tcr_pkg::CMD_CONVERT);
      chk_bit(conv_busy, 1'b0, "frozen while disabled");
      @(posedge mclk);
      clk_en <= 1'b1;
      @(posedge mclk);
      #1;
      chk_bit(conv_busy, 1'b0, "no late start after enable");
   endtask : t_freeze

   task automatic t_res_sweep;
      for (int r = 0; r < 4; r++)
      begin
         nv_write(tcr_pkg::NV_CONFIG, {1'b0, r[1:0], 5'h1f});
         conv_run(12'h066f, r[1:0]);
      end
      conv_run(12'h0fff, tcr_pkg::RES_12);
      conv_run(12'h0000, tcr_pkg::RES_12);
   endtask : t_res_sweep

   task automatic t_nv;
      for (int i = 0; i < 5; i++)
         nv_write(i[2:0], 8'h3c + 8'(i));
      nv_write(3'h5, 8'h99);
      for (int i = 0; i < 5; i++)
         nv_read(i[2:0], 8'h3c + 8'(i));
      nv_read(3'h5, 8'h00);
   endtask : t_nv

   task automatic t_parasite;
      vdd_pin <= 1'b0;
      repeat (4) @(posedge mclk);
      conv_run(12'h0991, tcr_pkg::RES_12);
      vdd_pin <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask : t_parasite

   initial
   begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      rd_slot = 1'b0;
      vdd_pin = 1'b1;
      nv_wr = 1'b0;
      nv_rd = 1'b0;
      nv_addr = 3'h0;
      nv_wdata = 8'h00;
      strong_pu = 1'b0;
      target = 12'h0991;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_freeze();
      conv_run(12'h0991, tcr_pkg::RES_12);
      t_nv();
      t_res_sweep();
      t_parasite();
      finish_test();
   end
endmodule : testbench
